/* File: hdl/vlbr_top.sv */
// Line bit recovery: field arming, line gating, bit clock, check and unload
//
// Contract
// - Start stage armed only on enabled lines
// - First data bit sets start stage
// - Timing runs from eight-times reference clock
// - Divider makes pulses at the bit rate
// - Rising data edges realign the divider phase
// - Sample point sits mid bit cell
// - Inverted data shifts into check register
// - Complete only at 90 bits with valid check
// - Completion stops bit clock, raises ready
`timescale 1ns/100ps
`include "vlbr_cfg.svh"

// ---------------------------------------------------------------
// Output buffer
// ---------------------------------------------------------------
module vlbr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output      logic             inReady,
  output      logic [WIDTH-1:0] outData,
  output      logic             outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words
  logic [AW:0]      wrPtr_reg;    // Write pointer with wrap bit
  logic [AW:0]      rdPtr_reg;    // Read pointer with wrap bit
  logic             full;         // No room left
  logic             empty;        // Nothing stored
  logic             push;         // Word accepted
  logic             pop;          // Word taken

  // Pointer wrap bits tell full from empty without a spare slot
  assign empty    = (wrPtr_reg == rdPtr_reg);
  assign full     = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                    (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign push     = inValid && !full;
  assign pop      = outReady && !empty;
  assign outData  = mem[rdPtr_reg[AW-1:0]];

  // Storage write; memory needs no reset since pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  // Pointer update
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule : vlbr_fifo

// ---------------------------------------------------------------
// Recovery top
// ---------------------------------------------------------------
module vlbr_top (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               fieldArm,
  input  wire logic [31:0]        lineEnableMask,
  input  wire logic               lineSyncPin,
  input  wire logic               vitcDataPin,
  output      logic               codeWordReady,
  output      vlbr_pkg::vlbr_byte_t outByte,
  output      logic               outValid,
  input  wire logic               outReady
);
  import vlbr_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [2:0]            dataSync_reg;   // Data pin synchroniser plus edge stage
  logic [2:0]            lineSync_reg;   // Line sync synchroniser plus edge stage
  logic                  dataRise;       // Rising data transition
  logic                  lineRise;       // Start of a new line
  logic                  dataBit;        // Synchronised data level
  vlbr_state_t           state_reg;      // Sequence state
  vlbr_state_t           state_next;     // Next sequence state
  logic [4:0]            lineCnt_reg;    // Lines seen since arming
  logic                  lineOn;         // Current line is enabled
  logic [`VLBR_PH_W-1:0] phase_reg;      // Position inside bit cell
  logic                  bitStrobe;      // Recovered bit clock
  logic [6:0]            bitCnt_reg;     // Bits taken on this line
  logic [7:0]            crc_reg;        // Check register
  logic [7:0]            crc_next;       // Check after this bit
  logic                  lastBit;        // This strobe takes bit 90
  logic                  wordGood;       // 90 bits and check clean
  logic [`VLBR_WORD_W-1:0] word_reg;     // Captured code word
  logic [`VLBR_PAD_W-1:0]  wordPad;      // Word padded to whole bytes
  logic [3:0]            byteIdx_reg;    // Next byte to unload
  logic                  unloading_reg;  // Unload in progress
  logic                  fifoInReady;    // Buffer has room
  logic [8:0]            fifoOut;        // Buffer head word
  vlbr_byte_t            pushByte;       // Byte offered to buffer
  logic                  pushValid;      // Byte offer valid

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Two flops guard against metastability; the third only feeds
  // edge detection so the first flop is read by nothing else
  always_ff @(posedge clk) begin
    if (srst) begin
      dataSync_reg <= 3'h0;
      lineSync_reg <= 3'h0;
    end else begin
      dataSync_reg <= {dataSync_reg[1:0], vitcDataPin};
      lineSync_reg <= {lineSync_reg[1:0], lineSyncPin};
    end
  end

  // Level and edges come only from the settled second and third flops
  assign dataBit  = dataSync_reg[1];
  assign dataRise = dataSync_reg[1] && !dataSync_reg[2];
  assign lineRise = lineSync_reg[1] && !lineSync_reg[2];

  // ---------------------------------------------------------------
  // Line gating
  // ---------------------------------------------------------------
  // Line count restarts when the controller arms for a field; the
  // controller picks which lines are legal for its standard
  always_ff @(posedge clk) begin
    if (srst || fieldArm) begin
      lineCnt_reg <= `VLBR_LINE_ZERO;
    end else if (lineRise && lineCnt_reg != `VLBR_LINE_MAX) begin
      lineCnt_reg <= lineCnt_reg + 1'b1;
    end
  end

  // Count saturates so a long field cannot wrap back onto an early line
  assign lineOn = lineEnableMask[lineCnt_reg];

  // ---------------------------------------------------------------
  // Bit clock recovery
  // ---------------------------------------------------------------
  // clk stands in for the eight-times reference the phase
  // wraps every VLBR_DIV_CYCLES cycles to make the bit rate
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_reg <= `VLBR_PH_ZERO;
    end else if (dataRise) begin
      phase_reg <= `VLBR_PH_ZERO + 1'b1;
    end else if (phase_reg == `VLBR_PH_LAST) begin
      phase_reg <= `VLBR_PH_ZERO;
    end else begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // Strobe mid cell, only while receiving; completion stops it
  assign bitStrobe = (state_reg == VLBR_RECV) &&
                     (phase_reg == `VLBR_PH_MID) && !dataRise;

  // ---------------------------------------------------------------
  // Check and completion detect
  // ---------------------------------------------------------------
  // Data enters inverted, divisor x^8 + 1
  assign crc_next = {crc_reg[6:0], crc_reg[7] ^ !dataBit};
  assign lastBit  = bitStrobe && (bitCnt_reg == `VLBR_BITS - 7'h01);
  // A zero remainder after the last bit marks a clean word
  assign wordGood = lastBit && (crc_next == `VLBR_CRC_ZERO);

  // Check register and bit counter sit in reset outside the start stage
  always_ff @(posedge clk) begin
    if (srst || state_reg != VLBR_RECV) begin
      crc_reg    <= `VLBR_CRC_ZERO;
      bitCnt_reg <= `VLBR_BCNT_ZERO;
    end else if (bitStrobe) begin
      crc_reg    <= crc_next;
      bitCnt_reg <= bitCnt_reg + 1'b1;
    end
  end

  // Word shift; frozen once complete so the controller sees it intact
  always_ff @(posedge clk) begin
    if (srst) begin
      word_reg <= '0;
    end else if (bitStrobe) begin
      word_reg <= {dataBit, word_reg[`VLBR_WORD_W-1:1]};
    end
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  // Arming wins over every other event but reset: apart from srst it is the only way out of DONE
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      VLBR_IDLE: begin
        state_next = VLBR_IDLE;
      end
      VLBR_HUNT: begin
        if (lineOn && dataRise) begin
          state_next = VLBR_RECV;
        end
      end
      VLBR_RECV: begin
        if (wordGood) begin
          state_next = VLBR_DONE;
        end else if (lastBit || lineRise) begin
          state_next = VLBR_HUNT;
        end
      end
      VLBR_DONE: begin
        state_next = VLBR_DONE;
      end
      default: begin
        state_next = VLBR_IDLE;
      end
    endcase
    if (fieldArm) begin
      state_next = VLBR_HUNT;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= VLBR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ready follows the completion stage directly
  assign codeWordReady = (state_reg == VLBR_DONE);

  // ---------------------------------------------------------------
  // Word unload into the buffer
  // ---------------------------------------------------------------
  // Bytes go out first-received bit in bit 0; the last byte carries
  // two bits with zero fill above them
  assign wordPad        = {`VLBR_PAD_FILL, word_reg};
  assign pushByte.data  = wordPad[{byteIdx_reg, 3'h0} +: 8];
  assign pushByte.last  = (byteIdx_reg == `VLBR_BYTE_LAST);
  assign pushValid      = unloading_reg;

  // Unloader stalls on a full buffer so no byte is dropped
  always_ff @(posedge clk) begin
    if (srst || fieldArm) begin
      unloading_reg <= 1'b0;
      byteIdx_reg   <= `VLBR_BYTE_ZERO;
    end else if (state_reg == VLBR_RECV && wordGood) begin
      unloading_reg <= 1'b1;
      byteIdx_reg   <= `VLBR_BYTE_ZERO;
    end else if (unloading_reg && fifoInReady) begin
      if (pushByte.last) begin
        unloading_reg <= 1'b0;
      end else begin
        byteIdx_reg <= byteIdx_reg + 1'b1;
      end
    end
  end

  // Buffer between unloader and controller
  vlbr_fifo #(
    .WIDTH ($bits(vlbr_byte_t)),
    .DEPTH (`VLBR_FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .srst     (srst || fieldArm),
    .inData   (pushByte),
    .inValid  (pushValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (outValid),
    .outReady (outReady)
  );

  assign outByte = vlbr_byte_t'(fifoOut);

endmodule : vlbr_top

/* File: hdl/vlbr_cfg.svh */
// Constants for the line bit recovery block: counts, widths and reset values
`ifndef VLBR_CFG_SVH
`define VLBR_CFG_SVH

// ---------------------------------------------------------------
// Reference and bit rates (kHz, figures as printed)
// ---------------------------------------------------------------
`define VLBR_REF_KHZ_525   14318.18
`define VLBR_REF_KHZ_625   14500.0
`define VLBR_BIT_KHZ_525   1789.77
`define VLBR_BIT_KHZ_625   1812.5
`define VLBR_REF_PER_BIT   8
// Reference cycles per bit, derived from the two rates
`define VLBR_DIV_CYCLES    ($rtoi(`VLBR_REF_KHZ_525 / `VLBR_BIT_KHZ_525 + 0.5))

// ---------------------------------------------------------------
// Bit cell phase counter
// ---------------------------------------------------------------
`define VLBR_PH_W          3
`define VLBR_PH_ZERO       3'h0
`define VLBR_PH_LAST       3'h7
`define VLBR_PH_MID        3'h4

// ---------------------------------------------------------------
// Word and check
// ---------------------------------------------------------------
`define VLBR_BITS          7'h5a
`define VLBR_BCNT_ZERO     7'h00
`define VLBR_WORD_W        90
`define VLBR_PAD_W         96
`define VLBR_PAD_FILL      6'h00
`define VLBR_CRC_ZERO      8'h00
`define VLBR_BYTE_LAST     4'hb
`define VLBR_BYTE_ZERO     4'h0

// ---------------------------------------------------------------
// Line counting and buffering
// ---------------------------------------------------------------
`define VLBR_LINE_ZERO     5'h00
`define VLBR_LINE_MAX      5'h1f
`define VLBR_FIFO_DEPTH    8

`endif

/* File: hdl/vlbr_pkg.sv */
// Types shared by the line bit recovery block
package vlbr_pkg;

  // Recovery sequence states
  typedef enum logic [1:0] {
    VLBR_IDLE,
    VLBR_HUNT,
    VLBR_RECV,
    VLBR_DONE
  } vlbr_state_t;

  // One byte of the captured code word on its way out
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } vlbr_byte_t;

endpackage : vlbr_pkg

/* File: dv/vlbr_slicer_model.sv */
// Slicer model: line sync pulses and one code word per line on the data pin
`timescale 1ns/100ps
module vlbr_slicer_model (
  input  wire logic clk,
  output      logic lineSyncPin,
  output      logic vitcDataPin
);
  // Comparator output is always driven, so it rests at black level
  initial begin
    lineSyncPin = 1'b0;
    vitcDataPin = 1'b0;
  end

  // ---------------------------------------------------------------
  // One video line: sync, a gap of chosen length, then 90 bits
  // ---------------------------------------------------------------
  task automatic sendLine(input logic [89:0] word, input int gap);
    @(posedge clk) lineSyncPin <= 1'b1;
    repeat (4) @(posedge clk);
    lineSyncPin <= 1'b0;
    // A long gap plays a slow source; the first bit is always a one
    repeat (gap) @(posedge clk);
    for (int k = 0; k < 90; k++) begin
      vitcDataPin <= word[k];
      repeat (8) @(posedge clk);
    end
    vitcDataPin <= 1'b0;
  endtask : sendLine
endmodule : vlbr_slicer_model

/* File: dv/vlbr_top_properties.sv */
// Port checks for the recovery top
`timescale 1ns/100ps
module vlbr_top_properties (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 fieldArm,
  input wire logic [31:0]          lineEnableMask,
  input wire logic                 codeWordReady,
  input wire vlbr_pkg::vlbr_byte_t outByte,
  input wire logic                 outValid,
  input wire logic                 outReady
);
  import vlbr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------
  // Helper counters, both restart on arm
  // ---------------------------------------------------------------
  logic [9:0] armAge_reg;  // Cycles since arm, saturating
  logic [3:0] byteCnt_reg; // Bytes taken since arm
  always_ff @(posedge clk) begin
    if (srst || fieldArm) begin
      armAge_reg <= 10'h000;
    end else if (armAge_reg != 10'h3ff) begin
      armAge_reg <= armAge_reg + 10'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || fieldArm) begin
      byteCnt_reg <= 4'h0;
    end else if (outValid && outReady) begin
      byteCnt_reg <= byteCnt_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_arm_clears_all: assert property (fieldArm |=> !codeWordReady && !outValid)
    else $error("arm left ready or buffer set");
  a_ready_holds: assert property (codeWordReady && !fieldArm && !srst |=> codeWordReady)
    else $error("ready dropped without arm");
  a_head_stands: assert property (outValid && !outReady && !fieldArm && !srst
    |=> outValid && $stable(outByte))
    else $error("head byte changed while waiting");
  a_ready_unloads: assert property ($rose(codeWordReady) |-> ##[0:3] outValid)
    else $error("no byte after ready");
  a_word_time: assert property ($rose(codeWordReady) |-> armAge_reg >= 10'h2d0)
    else $error("ready before ninety bit cells");
  a_last_count: assert property (outValid && outReady
    |-> outByte.last == (byteCnt_reg == 4'hb))
    else $error("last flag on wrong byte");
  a_no_idle_out: assert property (!codeWordReady |-> !outValid)
    else $error("byte out without ready");
  a_last_padded: assert property (outValid && outByte.last
    |-> outByte.data[7:2] == 6'h00)
    else $error("pad bits of last byte set");
  a_line_gate: assert property ($rose(codeWordReady) |-> lineEnableMask != 32'h0)
    else $error("ready with no line enabled");
endmodule : vlbr_top_properties

bind vlbr_top vlbr_top_properties chk (
  .clk(clk), .srst(srst), .fieldArm(fieldArm), .lineEnableMask(lineEnableMask),
  .codeWordReady(codeWordReady), .outByte(outByte), .outValid(outValid),
  .outReady(outReady));

/* File: dv/vitc_line_bit_recovery_tb.sv */
// Self-checking bench for the recovery top
`timescale 1ns/100ps
module vitc_line_bit_recovery_tb;
  import vlbr_pkg::*;
  logic        clk, srst, fieldArm, codeWordReady, outValid, lineSyncPin, vitcDataPin;
  logic        outReady = 1'b0; // Driven by the stall process
  logic        stall    = 1'b1; // Hold the buffer full while set
  logic [31:0] lineEnableMask;
  logic [31:0] rngState = 32'h0000000c;
  logic [89:0] w;
  vlbr_byte_t  outByte;
  vlbr_byte_t  expQ[$];        // Expected bytes, oldest first
  int          nMismatch = 0, checksDone = 0;

  vlbr_top dut (.clk(clk), .srst(srst), .fieldArm(fieldArm), .lineEnableMask(lineEnableMask),
    .lineSyncPin(lineSyncPin), .vitcDataPin(vitcDataPin), .codeWordReady(codeWordReady),
    .outByte(outByte), .outValid(outValid), .outReady(outReady));
  vlbr_slicer_model slicer (.clk(clk), .lineSyncPin(lineSyncPin), .vitcDataPin(vitcDataPin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] nextRand();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : nextRand

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Random word whose last eight bits zero the check; good=0 spoils one bit
  function automatic logic [89:0] makeWord(input logic good);
    logic [89:0] v;
    logic [7:0]  c;
    logic [31:0] r;
    for (int k = 0; k < 90; k++) begin
      r = nextRand();
      v[k] = r[0];
    end
    v[0] = 1'b1;
    c = 8'h00;
    for (int k = 0; k < 82; k++) c = {c[6:0], c[7] ^ ~v[k]};
    for (int j = 0; j < 8; j++) v[82+j] = ~c[7-j];
    if (!good) v[85] = ~v[85];
    return v;
  endfunction : makeWord

  // Note the twelve bytes that a captured word must unload as
  task automatic expectWord(input logic [89:0] v);
    logic [95:0] p;
    p = {6'h00, v};
    for (int k = 0; k < 12; k++) expQ.push_back({p[8*k +: 8], k == 11});
  endtask : expectWord

  task automatic armField(input logic [31:0] m);
    @(posedge clk) fieldArm <= 1'b1;
    lineEnableMask <= m;
    @(posedge clk) fieldArm <= 1'b0;
    @(negedge clk) check("readyAfterArm", {8'h00, codeWordReady}, 9'h000);
  endtask : armField

  task automatic waitReady(input logic exp);
    for (int i = 0; i < 40 && codeWordReady !== 1'b1; i++) @(negedge clk);
    check("ready", {8'h00, codeWordReady}, {8'h00, exp});
  endtask : waitReady

  task automatic drain();
    stall = 1'b0;
    for (int i = 0; i < 600 && expQ.size() != 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    check("leftOver", expQ.size(), 9'h000);
  endtask : drain

  task summarize;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Controller reads: random stalls, full stop while stall is set
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    logic [31:0] r;
    r = nextRand();
    outReady <= !stall && (r[1:0] != 2'h0);
  end
  // Head and ready settle well before the falling edge and stand until the
  // next rising edge takes the byte, so look there rather than at the launch
  always @(negedge clk) begin
    if (outValid === 1'b1 && outReady === 1'b1) begin
      if (expQ.size() == 0) check("spareByte", 9'h1ff, 9'h000);
      else check("outByte", outByte, expQ.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    fieldArm = 1'b0;
    lineEnableMask = 32'h0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // Only line 2 enabled: line 1 word ignored, line 2 word captured
    armField(32'h00000004);
    slicer.sendLine(makeWord(1'b1), 20);
    waitReady(1'b0);
    w = makeWord(1'b1);
    expectWord(w);
    slicer.sendLine(w, 3);
    waitReady(1'b1);
    repeat (60) @(posedge clk);
    drain();
    // Spoiled word on line 1, retry on line 2, line 3 word must not disturb
    armField(32'h0000000e);
    slicer.sendLine(makeWord(1'b0), 7);
    waitReady(1'b0);
    w = makeWord(1'b1);
    expectWord(w);
    slicer.sendLine(w, 11);
    waitReady(1'b1);
    drain();
    slicer.sendLine(makeWord(1'b1), 2);
    repeat (20) @(negedge clk);
    check("readyHeld", {8'h00, codeWordReady}, 9'h001);
    // Reset in mid field, while a word is held, clears everything
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    @(negedge clk) check("resetOut", {7'h00, outValid, codeWordReady}, 9'h000);
    armField(32'h0);
    summarize();
  end

  // Watchdog well beyond the five lines sent
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    summarize();
  end
endmodule : vitc_line_bit_recovery_tb
